// ===== logic/sag_pkg.sv
// Purpose: constants for spectral gain, flicker and auto-zero configuration
// Assumes: byte-wide register port, 10 MHz system clock
// Notes:   offsets are the printed byte addresses
package sag_pkg;
  localparam logic [7:0] ADDR_PERS     = 8'h65;
  localparam logic [7:0] ADDR_SGAIN    = 8'hc6;
  localparam logic [7:0] ADDR_FTIME_LO = 8'he0;
  localparam logic [7:0] ADDR_FTIME_HI = 8'he2;

  localparam int PERS_LSB  = 0;
  localparam int PERS_MSB  = 2;
  localparam int SGAIN_LSB = 0;
  localparam int SGAIN_MSB = 4;
  localparam int FGAIN_LSB = 3;
  localparam int FGAIN_MSB = 7;
  localparam int THI_LSB   = 0;
  localparam int THI_MSB   = 2;

  localparam logic [2:0] PERS_RST  = 3'h2;
  localparam logic [4:0] SGAIN_RST = 5'h09;
  localparam logic [4:0] FGAIN_RST = 5'h09;
  localparam logic [2:0] THI_RST   = 3'h1;
  localparam logic [7:0] TLO_RST   = 8'h67;
  localparam logic [4:0] GAIN_MAX  = 5'h0c;

  localparam int NUM_CH      = 6;
  localparam int FLK_CH      = 5;
  localparam int STEP_PS     = 2780;
  localparam int CLK_NS      = 100;
  localparam int AZ_TIME_US  = 15000;
  localparam int AZ_CYCLES   = (AZ_TIME_US * 1000) / CLK_NS;
  localparam int AZ_CNT_W    = 18;
endpackage : sag_pkg

// ===== logic/sag_az_timer.sv
// Purpose: auto-zero operation timer
// Assumes: start is a one-cycle pulse
// Notes:   starts while busy are ignored
`timescale 1ns/1ps
module sag_az_timer #(
  parameter int AZ_CYCLES = sag_pkg::AZ_CYCLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);
  typedef enum logic {SAG_AZ_IDLE, SAG_AZ_RUN} sag_az_e;
  typedef struct packed {
    sag_az_e                        st;
    logic [sag_pkg::AZ_CNT_W-1:0]   cnt;
    logic                           busy;
    logic                           done;
  } sag_az_s;

  localparam logic [sag_pkg::AZ_CNT_W-1:0] LAST = sag_pkg::AZ_CNT_W'(AZ_CYCLES - 1);

  sag_az_s s_r;
  sag_az_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      SAG_AZ_IDLE: begin
        if (start) begin
          s_nxt.st   = SAG_AZ_RUN;
          s_nxt.cnt  = '0;
          s_nxt.busy = 1'b1;
        end
      end
      SAG_AZ_RUN: begin
        if (s_r.cnt == LAST) begin
          s_nxt.st   = SAG_AZ_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
      default: s_nxt.st = SAG_AZ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '{st: SAG_AZ_IDLE, cnt: '0, busy: 1'b0, done: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign done = s_r.done;
endmodule : sag_az_timer

// ===== logic/sag_top.sv
// Purpose: ADC gain, flicker time, persistence and auto-zero control
// Assumes: host register port is synchronous to SYS_CLK
// Notes:   read data is valid one cycle after the address
//
// Notes on behaviour
// - six ADC channels get gain settings and auto-zero control
// - spectral gain code in bits 4:0, reset value 9, 0.5x doubling to 2048x
// - flicker gain code in bits 7:3, reset 9, drives only channel 5
// - flicker step high bits 2:0 reset 1; frozen while flicker enabled and powered
// - flicker status changes after enough consecutive differing results; 3-bit setting, reset 2
// - needed count is two to the setting minus one; zero updates every result
// - flicker interrupt event only when persisted status changes
// - auto-zero of spectral engines started by AZ_REQUEST when idle (requests while busy ignored), about 15 ms each
// - channel 5 follows spectral settings unless flicker enable is set
// - flicker step count is 11 bits, time equals count times 2.78 ns
`timescale 1ns/1ps
module sag_top #(
  parameter int AZ_CYCLES = sag_pkg::AZ_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        SRST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_WDATA,
  output logic      [7:0]  REG_RDATA,
  input  wire logic        FLICKER_ENABLE,
  input  wire logic        POWER_ON_BIT,
  input  wire logic        FLICKER_RESULT_VALID,
  input  wire logic        FLICKER_RESULT,
  input  wire logic        AZ_REQUEST,
  output logic      [4:0]  SPECTRAL_GAIN,
  output logic      [4:0]  ADC5_GAIN,
  output logic             ADC5_FLICKER_TIMING,
  output logic      [10:0] FLICKER_STEPS,
  output logic             FLICKER_STATUS,
  output logic             FLICKER_IRQ_EVENT,
  output logic      [5:0]  AZ_CHANNEL_MASK,
  output logic             AZ_BUSY,
  output logic             AZ_DONE
);
  typedef struct packed {
    logic [2:0]  pers;
    logic [4:0]  sgain;
    logic [4:0]  fgain;
    logic [2:0]  thigh;
    logic [7:0]  tlow;
    logic [6:0]  cnt;
    logic        status;
    logic        irq;
    logic [7:0]  rdata;
    logic [4:0]  adc5_gain;
    logic        adc5_sep;
    logic [10:0] steps;
    logic [5:0]  az_mask;
  } sag_main_s;

  sag_main_s s_r;
  sag_main_s s_nxt;

  function automatic logic gain_ok(input logic [4:0] code);
    return code <= sag_pkg::GAIN_MAX;
  endfunction : gain_ok

  function automatic logic [6:0] pers_need(input logic [2:0] p);
    return (p == 3'h0) ? 7'h01 : 7'(7'h01 << (p - 3'h1));
  endfunction : pers_need

  logic       time_lock;
  logic [4:0] wr_sgain;
  logic [4:0] wr_fgain;
  logic [6:0] cnt_inc;

  assign wr_sgain = REG_WDATA[sag_pkg::SGAIN_MSB:sag_pkg::SGAIN_LSB];
  assign wr_fgain = REG_WDATA[sag_pkg::FGAIN_MSB:sag_pkg::FGAIN_LSB];
  assign cnt_inc  = s_r.cnt + 7'h01;
  assign time_lock = FLICKER_ENABLE & POWER_ON_BIT;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt     = s_r;
    s_nxt.irq = 1'b0;
    if (REG_WR) begin
      case (REG_ADDR)
        sag_pkg::ADDR_PERS: begin
          s_nxt.pers = REG_WDATA[sag_pkg::PERS_MSB:sag_pkg::PERS_LSB];
        end
        sag_pkg::ADDR_SGAIN: begin
          if (gain_ok(wr_sgain)) begin
            s_nxt.sgain = wr_sgain;
          end
        end
        sag_pkg::ADDR_FTIME_LO: begin
          if (!time_lock) begin
            s_nxt.tlow = REG_WDATA;
          end
        end
        sag_pkg::ADDR_FTIME_HI: begin
          if (gain_ok(wr_fgain)) begin
            s_nxt.fgain = wr_fgain;
          end
          if (!time_lock) begin
            s_nxt.thigh = REG_WDATA[sag_pkg::THI_MSB:sag_pkg::THI_LSB];
          end
        end
        default: begin
        end
      endcase
    end

    if (FLICKER_RESULT_VALID) begin
      if (FLICKER_RESULT == s_r.status) begin
        s_nxt.cnt = 7'h00;
      end else if (cnt_inc >= pers_need(s_r.pers)) begin
        s_nxt.cnt    = 7'h00;
        s_nxt.status = FLICKER_RESULT;
        s_nxt.irq    = 1'b1;
      end else begin
        s_nxt.cnt = cnt_inc;
      end
    end

    case (REG_ADDR)
      sag_pkg::ADDR_PERS:     s_nxt.rdata = {5'h00, s_r.pers};
      sag_pkg::ADDR_SGAIN:    s_nxt.rdata = {3'h0, s_r.sgain};
      sag_pkg::ADDR_FTIME_LO: s_nxt.rdata = s_r.tlow;
      sag_pkg::ADDR_FTIME_HI: s_nxt.rdata = {s_r.fgain, s_r.thigh};
      default:                s_nxt.rdata = 8'h00;
    endcase

    s_nxt.adc5_sep  = FLICKER_ENABLE;
    s_nxt.adc5_gain = FLICKER_ENABLE ? s_r.fgain : s_r.sgain;
    s_nxt.steps     = {s_r.thigh, s_r.tlow};
    // auto-zero covers ch5 with flicker on
    s_nxt.az_mask   = {FLICKER_ENABLE, 5'h1f};
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      s_r <= '{pers: sag_pkg::PERS_RST, sgain: sag_pkg::SGAIN_RST,
               fgain: sag_pkg::FGAIN_RST, thigh: sag_pkg::THI_RST,
               tlow: sag_pkg::TLO_RST, cnt: 7'h00, status: 1'b0, irq: 1'b0,
               rdata: 8'h00, adc5_gain: sag_pkg::SGAIN_RST, adc5_sep: 1'b0,
               steps: {sag_pkg::THI_RST, sag_pkg::TLO_RST}, az_mask: 6'h1f};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // auto-zero duration
  sag_az_timer #(
    .AZ_CYCLES (AZ_CYCLES)
  ) u_az (
    .clk   (SYS_CLK),
    .srst  (SRST),
    .start (AZ_REQUEST),
    .busy  (AZ_BUSY),
    .done  (AZ_DONE)
  );

  assign REG_RDATA           = s_r.rdata;
  assign SPECTRAL_GAIN       = s_r.sgain;
  assign ADC5_GAIN           = s_r.adc5_gain;
  assign ADC5_FLICKER_TIMING = s_r.adc5_sep;
  assign FLICKER_STEPS       = s_r.steps;
  assign FLICKER_STATUS      = s_r.status;
  assign FLICKER_IRQ_EVENT   = s_r.irq;
  assign AZ_CHANNEL_MASK     = s_r.az_mask;
endmodule : sag_top

// ===== verification/sag_top_properties.sv
// Purpose: port checks for sag_top
// Assumes: one clock domain, sync reset
// Notes:   AZ_CYCLES follows the bound instance
`timescale 1ns/1ps
module sag_checker #(
  parameter int AZ_CYCLES = 8
) (
  input wire logic        SYS_CLK,
  input wire logic        SRST,
  input wire logic [7:0]  REG_ADDR,
  input wire logic        REG_WR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        FLICKER_ENABLE,
  input wire logic        POWER_ON_BIT,
  input wire logic        AZ_REQUEST,
  input wire logic [4:0]  SPECTRAL_GAIN,
  input wire logic [4:0]  ADC5_GAIN,
  input wire logic        ADC5_FLICKER_TIMING,
  input wire logic [10:0] FLICKER_STEPS,
  input wire logic        FLICKER_STATUS,
  input wire logic        FLICKER_IRQ_EVENT,
  input wire logic [5:0]  AZ_CHANNEL_MASK,
  input wire logic        AZ_BUSY,
  input wire logic        AZ_DONE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  int az_n = 0;
  always_ff @(posedge SYS_CLK) az_n <= AZ_BUSY ? az_n + 1 : 0;
  ////////////////////////////////////////////////////////////////////////////
  a_gain_taken: assert property (REG_WR && REG_ADDR == 8'hc6 && REG_WDATA[4:0] <= 5'h0c
    |=> SPECTRAL_GAIN == $past(REG_WDATA[4:0])) else $error("gain write lost");
  a_gain_reserved: assert property (REG_WR && REG_ADDR == 8'hc6 && REG_WDATA[4:0] > 5'h0c
    |=> $stable(SPECTRAL_GAIN)) else $error("reserved gain taken");
  a_adc5_follow: assert property ((!FLICKER_ENABLE && $stable(SPECTRAL_GAIN)) [*3]
    |-> ADC5_GAIN == SPECTRAL_GAIN) else $error("ch5 gain not shared");
  a_timing_lag: assert property (!$past(SRST)
    |-> ADC5_FLICKER_TIMING == $past(FLICKER_ENABLE)) else $error("ch5 timing wrong");
  a_mask_ch5: assert property (AZ_CHANNEL_MASK == {ADC5_FLICKER_TIMING, 5'h1f})
    else $error("auto-zero mask wrong");
  a_irq_change: assert property (FLICKER_IRQ_EVENT == (FLICKER_STATUS != $past(FLICKER_STATUS)))
    else $error("flicker event mismatch");
  a_steps_frozen: assert property (FLICKER_ENABLE && POWER_ON_BIT && REG_WR
    && REG_ADDR inside {8'he0, 8'he2} |-> ##2 $stable(FLICKER_STEPS)) else $error("steps moved");
  a_az_start: assert property (AZ_REQUEST && !AZ_BUSY |=> AZ_BUSY)
    else $error("auto-zero not started");
  a_az_length: assert property ($fell(AZ_BUSY) |-> AZ_DONE && az_n == AZ_CYCLES)
    else $error("auto-zero length wrong");
  a_done_single: assert property (AZ_DONE |=> !AZ_DONE) else $error("done too long");
endmodule : sag_checker

bind sag_top sag_checker #(.AZ_CYCLES(AZ_CYCLES)) sag_checker_i (.SYS_CLK(SYS_CLK), .SRST(SRST),
  .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .FLICKER_ENABLE(FLICKER_ENABLE),
  .POWER_ON_BIT(POWER_ON_BIT), .AZ_REQUEST(AZ_REQUEST), .SPECTRAL_GAIN(SPECTRAL_GAIN),
  .ADC5_GAIN(ADC5_GAIN), .ADC5_FLICKER_TIMING(ADC5_FLICKER_TIMING),
  .FLICKER_STEPS(FLICKER_STEPS), .FLICKER_STATUS(FLICKER_STATUS),
  .FLICKER_IRQ_EVENT(FLICKER_IRQ_EVENT), .AZ_CHANNEL_MASK(AZ_CHANNEL_MASK),
  .AZ_BUSY(AZ_BUSY), .AZ_DONE(AZ_DONE));

// ===== verification/sag_host_model.sv
// Purpose: host writing and reading config registers
// Assumes: drives 1 ns after the rising edge
// Notes:   brk lets one write break the frozen-time rule
`timescale 1ns/1ps
module sag_host_model (
  input  wire logic       clk,
  input  wire logic       fen,
  input  wire logic       power_on_bit,
  input  wire logic [7:0] rdata,
  output logic      [7:0] addr,
  output logic            wr,
  output logic      [7:0] wdata
);
  initial addr = 8'h00;
  initial wr = 1'h0;
  initial wdata = 8'h00;
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input bit brk);
    @(posedge clk);
    #1;
    addr = a;
    wdata = d;
    wr = !(fen && power_on_bit && !brk && a inside {8'he0, 8'he2});
    @(posedge clk);
    #1;
    wr = 1'h0;
    wdata = ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    @(posedge clk);
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : sag_host_model

// ===== verification/test_sag_top.sv
// Purpose: self-checking bench for sag_top
// Assumes: auto-zero shortened to 8 cycles
// Notes:   rows hold write addr, data, read addr, expected
`timescale 1ns/1ps
module test_sag_top;
  logic [7:0]  addr, wdata, rdata, rv;
  logic [4:0]  sgain, a5gain;
  logic [10:0] steps;
  logic [5:0]  mask;
  logic        clk, srst, wr, fen, power_on_bit, fv, fr, azq, a5t, stat, irq, busy, done;
  int          fail_count = 0, n_compared = 0, irq_n = 0, k;
  logic [31:0] rows [14] = '{32'h5000c609, 32'h5000e249, 32'h50006502, 32'h5000e067,
    32'hc605c605, 32'hc6ffc605, 32'hc60cc60c, 32'hc60dc60c, 32'h65ff6507, 32'h65006500,
    32'he26ee24e, 32'he25ae25a, 32'he0a5e0a5, 32'h50125000};
  sag_top #(.AZ_CYCLES(8)) sag_top_i (.SYS_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .FLICKER_ENABLE(fen), .POWER_ON_BIT(power_on_bit),
    .FLICKER_RESULT_VALID(fv), .FLICKER_RESULT(fr), .AZ_REQUEST(azq), .SPECTRAL_GAIN(sgain),
    .ADC5_GAIN(a5gain), .ADC5_FLICKER_TIMING(a5t), .FLICKER_STEPS(steps),
    .FLICKER_STATUS(stat), .FLICKER_IRQ_EVENT(irq), .AZ_CHANNEL_MASK(mask), .AZ_BUSY(busy),
    .AZ_DONE(done));
  sag_host_model sag_host_model_i (.clk(clk), .fen(fen), .power_on_bit(power_on_bit), .rdata(rdata),
    .addr(addr), .wr(wr), .wdata(wdata));
  always @(posedge clk) if (irq === 1'h1) irq_n <= irq_n + 1;
  task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic res(input logic v, input int n);
    @(posedge clk);
    #1;
    fv = 1'h1;
    fr = v;
    repeat (n) @(posedge clk);
    #1;
    fv = 1'h0;
    fr = ~v;
  endtask : res
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    {srst, fen, power_on_bit, fv, fr, azq} = 6'h28;
    repeat (10) @(posedge clk);
    #1;
    srst = 1'h0;
    chk("steps", steps, 11'h167);
    chk("mask", {5'h0, mask}, 11'h1f);
    for (k = 0; k < 14; k++) begin
      sag_host_model_i.wr_reg(rows[k][31:24], rows[k][23:16], 1'h0);
      sag_host_model_i.rd_reg(rows[k][15:8], rv);
      chk("reg", {3'h0, rv}, {3'h0, rows[k][7:0]});
    end
    chk("ch5", {6'h0, a5gain}, 11'h0c);
    fen = 1'h1;
    repeat (2) @(posedge clk);
    #1;
    chk("ch5", {6'h0, a5gain}, 11'h0b);
    chk("mask", {5'h0, mask}, 11'h3f);
    sag_host_model_i.wr_reg(8'he0, 8'h00, 1'h1);
    sag_host_model_i.rd_reg(8'he0, rv);
    chk("steps", steps, 11'h2a5);
    chk("low", {3'h0, rv}, 11'h0a5);
    $display("register tests done");
    res(1'h1, 1);
    chk("status", {10'h0, stat}, 11'h1);
    sag_host_model_i.wr_reg(8'h65, 8'h03, 1'h0);
    res(1'h0, 3);
    res(1'h1, 1);
    res(1'h0, 3);
    chk("status", {10'h0, stat}, 11'h1);
    res(1'h0, 1);
    chk("status", {10'h0, stat}, 11'h0);
    @(posedge clk);
    #1;
    chk("events", 11'(irq_n), 11'h2);
    $display("persistence tests done");
    for (k = 0; k < 12; k++) begin
      @(posedge clk);
      #1;
      azq = (k == 0 || k == 3);
      if (done === 1'h1) break;
    end
    chk("az cycles", 11'(k), 11'h09);
    if (k == 12) end_of_test();
    @(posedge clk);
    #1;
    chk("az busy", {10'h0, busy}, 11'h0);
    $display("auto-zero tests done");
    end_of_test();
  end
endmodule : test_sag_top
